// ### rtl/twf_pkg.sv
// constants and types shared by the two-wire frame output block
package twf_pkg;

  // ----------------------------------------------------------------
  // clock and watchdog timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int WDT_TIME_NS    = 3600;
  localparam int WDT_CYCLES_INT = (WDT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] WDT_CYCLES = WDT_CYCLES_INT[9:0];

  // ----------------------------------------------------------------
  // conversion timing, in master clock periods, at ratio 64
  // ----------------------------------------------------------------
  localparam int OSR_MIN       = 64;
  localparam int SETTLE_CONVS  = 3;
  localparam int CONV_BASE_INT = 4 * OSR_MIN;
  localparam int START_BASE_INT = 2 * OSR_MIN + SETTLE_CONVS * CONV_BASE_INT;
  localparam logic [13:0] CONV_BASE  = CONV_BASE_INT[13:0];
  localparam logic [13:0] START_BASE = START_BASE_INT[13:0];
  localparam logic [13:0] CNT_ONE    = 14'h0001;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0]  RATIO_64     = 2'h0;
  localparam logic [7:0]  SYNC_BYTE    = 8'hA5;
  localparam logic [6:0]  LEN_SHORT    = 7'h30;
  localparam logic [6:0]  LEN_LONG     = 7'h40;
  localparam logic [6:0]  CRC_BITS     = 7'h10;
  localparam logic [1:0]  LAST_FRAME   = 2'h3;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_INIT     = 16'h0000;

  typedef enum logic [2:0] {
    TWF_IDLE = 3'h1,
    TWF_DATA = 3'h2,
    TWF_CRC  = 3'h4
  } twf_state_e;

endpackage

// ### rtl/twf_crc_if.sv
// interface between the framer and its frame checksum engine
`timescale 1ns/10ps
interface twf_crc_if;
  logic        clear;
  logic        shift;
  logic        data_bit;
  logic [15:0] crc;

  modport framer (output clear, output shift, output data_bit, input crc);
  modport engine (input clear, input shift, input data_bit, output crc);
endinterface

// ### rtl/twf_crc.sv
// serial frame checksum engine, msb first
`timescale 1ns/10ps
module twf_crc (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // framer side
  twf_crc_if.engine cif
);

  logic [15:0] base;
  logic        feedback;
  logic [15:0] next_crc;
  logic [15:0] crc;

  // ----------------------------------------------------------------
  // one bit step
  // ----------------------------------------------------------------
  always_comb begin
    base     = cif.clear ? twf_pkg::CRC_INIT : crc;
    feedback = base[15] ^ cif.data_bit;
    next_crc = {base[14:0], 1'b0} ^ (feedback ? twf_pkg::CRC_POLY : 16'h0000);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crc <= twf_pkg::CRC_INIT;
    end else if (cif.shift) begin
      crc <= next_crc;
    end
  end

  assign cif.crc = crc;

endmodule

// ### rtl/twf_framer.sv
// two-wire frame output with clock-high watchdog
//
// Behaviour
// RULE1 - host clocks the serial input without pause
// RULE2 - host keeps serial clock at 10 MHz max
// RULE3 - any clock duty cycle is accepted
// RULE4 - frames sent at fixed rate, clock-synchronous
// RULE5 - ratio 64: sync, two 16-bit results, checksum
// RULE6 - higher ratios: 80-bit frame, 24-bit results
// RULE7 - order: sync, channel 0, channel 1, checksum
// RULE8 - sync word reports five latched strap pins
// RULE9 - sync word carries 2-bit frame counter
// RULE10 - sync word holds fixed byte A5
// RULE11 - four frames per result, then output low
// RULE12 - ratio 64 streams back-to-back without gap
// RULE13 - no frames before first result settles
// RULE14 - conversions start after twice ratio clocks
// RULE15 - no hard reset input in this mode
// RULE16 - clock held high past timeout resets all
// RULE17 - clock low before timeout clears timer
// RULE18 - clock held low never resets
// RULE19 - host keeps clock at least 138.9 kHz
// RULE20 - host exits mode via select low, clock high
// RULE21 - output never floats, idles low
// RULE22 - straps captured on select rising edge
// RULE23 - interface choice latched at reset release
// RULE24 - checksum over sync and results, msb first
// RULE25 - watchdog timed by free-running internal clock
`timescale 1ns/10ps
module twf_framer (
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // link pins
  input  wire logic        serial_clock,
  output logic             serial_out,
  // strap pins
  input  wire logic        interface_select_pin,
  input  wire logic        ratio_select_low_pin,
  input  wire logic        ratio_select_high_pin,
  input  wire logic        gain_select_low_pin,
  input  wire logic        gain_select_high_pin,
  input  wire logic        bias_select_pin,
  // converter results
  input  wire logic [23:0] channel0_result,
  input  wire logic [23:0] channel1_result,
  output logic             result_take,
  // status
  output logic             two_wire_mode,
  output logic [1:0]       ratio_code,
  output logic [1:0]       gain_code,
  output logic             bias_code,
  output logic             converter_reset,
  output logic             watchdog_reset
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic       sck_m, sck_s, sck_d;
  logic       sel_m, sel_s, sel_d;
  logic [4:0] strap_m, strap_s;
  logic       sck_rise, sck_fall, sel_rise;

  // no reset here, so pins are settled when reset lets go [RULE23]
  always_ff @(posedge clk) begin
    sck_m   <= serial_clock;
    sck_s   <= sck_m;
    sck_d   <= sck_s;
    sel_m   <= interface_select_pin;
    sel_s   <= sel_m;
    sel_d   <= sel_s;
    strap_m <= {ratio_select_high_pin, ratio_select_low_pin,
                gain_select_high_pin, gain_select_low_pin, bias_select_pin};
    strap_s <= strap_m;
  end

  // edges seen on the oversampled clock, so duty cycle is free [RULE3]
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign sel_rise = sel_s & ~sel_d;

  // ----------------------------------------------------------------
  // watchdog on the internal clock
  // ----------------------------------------------------------------
  logic [9:0] wdt_count;
  logic       wdt_armed;
  logic       local_rst;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wdt_count      <= 10'h000;
      wdt_armed      <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= 1'b0;
      if (sck_rise) begin
        wdt_count <= 10'h001;  // [RULE16] [RULE25]
        wdt_armed <= 1'b1;
      end else if (!sck_s) begin
        wdt_count <= 10'h000;  // [RULE17] [RULE18]
        wdt_armed <= 1'b0;
      end else if (wdt_armed) begin
        if (wdt_count == twf_pkg::WDT_CYCLES) begin
          watchdog_reset <= 1'b1;  // [RULE16]
          wdt_armed      <= 1'b0;
        end else begin
          wdt_count <= wdt_count + 10'h001;
        end
      end
    end
  end

  // only power-on and watchdog reset the part [RULE15]
  assign local_rst = !rst_b || watchdog_reset;

  // ----------------------------------------------------------------
  // mode and strap latching
  // ----------------------------------------------------------------
  logic init_done;

  always_ff @(posedge clk) begin
    if (local_rst) begin
      init_done       <= 1'b0;
      two_wire_mode   <= 1'b0;
      ratio_code      <= 2'h0;
      gain_code       <= 2'h0;
      bias_code       <= 1'b0;
      converter_reset <= 1'b1;
    end else begin
      converter_reset <= 1'b0;
      if (!init_done) begin
        init_done     <= 1'b1;
        two_wire_mode <= sel_s;  // [RULE23]
        {ratio_code, gain_code, bias_code} <= strap_s;
      end else if (sel_rise) begin
        {ratio_code, gain_code, bias_code} <= strap_s;  // [RULE22]
      end
    end
  end

  // ----------------------------------------------------------------
  // result timing in master clock periods
  // ----------------------------------------------------------------
  logic [13:0] conv_count;
  logic        conv_started;
  logic        pending;
  logic        take;
  logic [23:0] ch0_q, ch1_q;

  always_ff @(posedge clk) begin
    if (local_rst || !two_wire_mode) begin
      conv_count   <= 14'h0000;
      conv_started <= 1'b0;
      result_take  <= 1'b0;
    end else begin
      result_take <= 1'b0;
      if (!conv_started) begin
        conv_started <= 1'b1;
        conv_count   <= (twf_pkg::START_BASE << ratio_code) - twf_pkg::CNT_ONE;  // [RULE14]
      end else if (sck_rise) begin
        if (conv_count == 14'h0000) begin
          result_take <= 1'b1;  // [RULE13]
          conv_count  <= (twf_pkg::CONV_BASE << ratio_code) - twf_pkg::CNT_ONE;  // [RULE4]
        end else begin
          conv_count <= conv_count - twf_pkg::CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (local_rst) begin
      ch0_q <= 24'h000000;
      ch1_q <= 24'h000000;
    end else if (result_take) begin
      ch0_q <= channel0_result;
      ch1_q <= channel1_result;
    end
  end

  // a new result wins over the take in the same cycle [RULE11]
  always_ff @(posedge clk) begin
    if (local_rst) begin
      pending <= 1'b0;
    end else begin
      pending <= (pending & ~take) | result_take;
    end
  end

  // ----------------------------------------------------------------
  // frame shifter
  // ----------------------------------------------------------------
  twf_crc_if           cif ();
  twf_pkg::twf_state_e state;
  logic [63:0]         payload;
  logic [63:0]         next_payload;
  logic [6:0]          bit_cnt;
  logic [1:0]          frame_idx;
  logic [15:0]         crc_sh;
  logic [6:0]          payload_len;
  logic                load_frame;
  logic [1:0]          load_idx;

  twf_crc u_crc (
    .clk   (clk),
    .rst_b (rst_b),
    .cif   (cif)
  );

  assign payload_len = (ratio_code == twf_pkg::RATIO_64) ? twf_pkg::LEN_SHORT
                                                         : twf_pkg::LEN_LONG;

  // sync word then channel 0 then channel 1 [RULE7] [RULE8] [RULE9] [RULE10]
  always_comb begin
    if (ratio_code == twf_pkg::RATIO_64) begin
      next_payload = {ratio_code, gain_code, bias_code, load_idx, 1'b0, twf_pkg::SYNC_BYTE,
                      ch0_q[23:8], ch1_q[23:8], 16'h0000};  // [RULE5]
    end else begin
      next_payload = {ratio_code, gain_code, bias_code, load_idx, 1'b0, twf_pkg::SYNC_BYTE,
                      ch0_q, ch1_q};  // [RULE6]
    end
  end

  always_comb begin
    load_frame = 1'b0;
    load_idx   = 2'h0;
    take       = 1'b0;
    if (sck_fall) begin
      case (state)
        twf_pkg::TWF_IDLE: begin
          load_frame = pending;
          take       = pending;
        end
        twf_pkg::TWF_CRC: begin
          if (bit_cnt == twf_pkg::CRC_BITS) begin
            if (frame_idx != twf_pkg::LAST_FRAME) begin
              load_frame = 1'b1;
              load_idx   = frame_idx + 2'h1;
            end else begin
              load_frame = pending;  // [RULE12]
              take       = pending;
            end
          end
        end
        default: begin
          load_frame = 1'b0;
        end
      endcase
    end
  end

  // checksum runs over every payload bit as it leaves [RULE24]
  assign cif.clear    = load_frame;
  assign cif.shift    = load_frame || (sck_fall && state == twf_pkg::TWF_DATA &&
                                       bit_cnt != payload_len);
  assign cif.data_bit = load_frame ? next_payload[63] : payload[63];

  always_ff @(posedge clk) begin
    if (local_rst || !two_wire_mode) begin
      state      <= twf_pkg::TWF_IDLE;
      serial_out <= 1'b0;  // [RULE21]
      payload    <= 64'h0;
      bit_cnt    <= 7'h00;
      frame_idx  <= 2'h0;
      crc_sh     <= 16'h0000;
    end else if (load_frame) begin
      state      <= twf_pkg::TWF_DATA;
      serial_out <= next_payload[63];  // [RULE4]
      payload    <= {next_payload[62:0], 1'b0};
      bit_cnt    <= 7'h01;
      frame_idx  <= load_idx;
    end else if (sck_fall) begin
      case (state)
        twf_pkg::TWF_DATA: begin
          if (bit_cnt == payload_len) begin
            state      <= twf_pkg::TWF_CRC;
            serial_out <= cif.crc[15];
            crc_sh     <= {cif.crc[14:0], 1'b0};
            bit_cnt    <= 7'h01;
          end else begin
            serial_out <= payload[63];
            payload    <= {payload[62:0], 1'b0};
            bit_cnt    <= bit_cnt + 7'h01;
          end
        end
        twf_pkg::TWF_CRC: begin
          if (bit_cnt == twf_pkg::CRC_BITS) begin
            state      <= twf_pkg::TWF_IDLE;
            serial_out <= 1'b0;  // [RULE11] [RULE21]
          end else begin
            serial_out <= crc_sh[15];
            crc_sh     <= {crc_sh[14:0], 1'b0};
            bit_cnt    <= bit_cnt + 7'h01;
          end
        end
        default: begin
          serial_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic seen_result;
  always_ff @(posedge clk) begin
    if (local_rst) begin
      seen_result <= 1'b0;
    end else if (result_take) begin
      seen_result <= 1'b1;
    end
  end

  a_idle_out_low: assert property (  // [RULE21]
    state == twf_pkg::TWF_IDLE |-> serial_out == 1'b0)
    else $error("output not low while idle");

  a_no_early_frame: assert property (  // [RULE13]
    state != twf_pkg::TWF_IDLE |-> seen_result)
    else $error("frame sent before first result");

  a_low_no_reset: assert property (  // [RULE18]
    !sck_d |=> !watchdog_reset)
    else $error("watchdog fired with clock low");

  a_wdt_high_time: assert property (  // [RULE16]
    $rose(watchdog_reset) |-> $past(sck_s, 1) && $past(sck_s, 300))
    else $error("watchdog fired without long high clock");

  a_low_clears: assert property (  // [RULE17]
    !sck_s |=> wdt_count == 10'h000 && !wdt_armed)
    else $error("watchdog timer not cleared on low clock");

  a_wdt_mode_drop: assert property (  // [RULE16] [RULE23]
    watchdog_reset |=> !two_wire_mode && state == twf_pkg::TWF_IDLE)
    else $error("watchdog did not reset the part");

  logic [15:0] next_payload_hold;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      next_payload_hold <= 16'h0000;
    end else begin
      next_payload_hold <= next_payload[63:48];
    end
  end

  a_sync_byte: assert property (  // [RULE10] [RULE9]
    load_frame && !local_rst && two_wire_mode |=>
      serial_out == next_payload_hold[15] && payload[56:49] == twf_pkg::SYNC_BYTE &&
      frame_idx == next_payload_hold[10:9])
    else $error("sync word malformed");

  a_crc_length: assert property (  // [RULE5] [RULE6]
    state == twf_pkg::TWF_CRC |-> bit_cnt <= twf_pkg::CRC_BITS && bit_cnt != 7'h00)
    else $error("checksum field overruns");

  a_frames_in_mode: assert property (  // [RULE4]
    state != twf_pkg::TWF_IDLE |-> two_wire_mode)
    else $error("framing outside two-wire mode");

  c_group_done: cover property (
    state == twf_pkg::TWF_CRC && frame_idx == twf_pkg::LAST_FRAME ##1
    state == twf_pkg::TWF_IDLE);
  c_back_to_back: cover property (
    state == twf_pkg::TWF_CRC ##1 state == twf_pkg::TWF_DATA && frame_idx == 2'h0);
  c_watchdog: cover property (watchdog_reset);

endmodule

// ### verification/twf_host_model.sv
// host model: clocks the link and samples the data line
`timescale 1ns/10ps
module twf_host_model #(
  parameter int HALF = 5
) (
  // clock
  input  wire logic clk,
  // bench control
  input  wire logic run,
  input  wire logic hold_high,
  input  wire logic skew,
  // link pins
  input  wire logic serial_out,
  output logic      serial_clock,
  // sampled bits
  output logic      bit_valid,
  output logic      bit_value
);
  int phase;

  // ----------------------------------------------------------------
  // link clock, 10 MHz, short high phase when skewed
  // ----------------------------------------------------------------
  initial begin
    serial_clock = 1'b0;
    bit_valid = 1'b0;
    bit_value = 1'b0;
    phase = 0;
  end

  always @(posedge clk) begin
    bit_valid <= 1'b0;
    if (hold_high) begin
      serial_clock <= 1'b1;
      phase <= 0;
    end else if (!run) begin
      serial_clock <= 1'b0;
      phase <= 0;
    end else if (phase >= (serial_clock ? (skew ? 1 : HALF - 1)
                                        : (skew ? 2 * HALF - 3 : HALF - 1))) begin
      phase <= 0;
      serial_clock <= !serial_clock;
      if (!serial_clock) begin
        bit_valid <= 1'b1;
        bit_value <= serial_out;
      end
    end else begin
      phase <= phase + 1;
    end
  end
endmodule

// ### verification/tb_top.sv
// frame output bench: straps, frames, idle, watchdog
`timescale 1ns/10ps
module tb_top;
  logic        clk;
  logic        rst_b;
  logic        run;
  logic        hold_high;
  logic        skew;
  logic        serial_clock;
  logic        serial_out;
  logic        bit_valid;
  logic        bit_value;
  logic        interface_select_pin;
  logic        ratio_select_low_pin;
  logic        ratio_select_high_pin;
  logic        gain_select_low_pin;
  logic        gain_select_high_pin;
  logic        bias_select_pin;
  logic [23:0] channel0_result;
  logic [23:0] channel1_result;
  logic        result_take;
  logic        two_wire_mode;
  logic [1:0]  ratio_code;
  logic [1:0]  gain_code;
  logic        bias_code;
  logic        converter_reset;
  logic        watchdog_reset;
  int          failures;
  int          checks_done;
  int          wd_pulses;

  twf_framer twf_framer_inst (
    .clk, .rst_b, .serial_clock, .serial_out, .interface_select_pin,
    .ratio_select_low_pin, .ratio_select_high_pin, .gain_select_low_pin,
    .gain_select_high_pin, .bias_select_pin, .channel0_result, .channel1_result,
    .result_take, .two_wire_mode, .ratio_code, .gain_code, .bias_code,
    .converter_reset, .watchdog_reset
  );

  twf_host_model twf_host_model_inst (
    .clk, .run, .hold_high, .skew, .serial_out, .serial_clock, .bit_valid, .bit_value
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (watchdog_reset === 1'b1) wd_pulses <= wd_pulses + 1;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [79:0] seen, input logic [79:0] expected);
    checks_done++;
    if (seen !== expected) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic bail();
    failures++;
    tally_and_finish();
  endtask

  // ----------------------------------------------------------------
  // link access
  // ----------------------------------------------------------------
  task automatic wait_take(output int bits, output logic quiet);
    bits = 0;
    quiet = 1'b1;
    for (int i = 0; i < 40000; i++) begin
      @(posedge clk);
      #1;
      if (bit_valid === 1'b1) bits++;
      if (serial_out !== 1'b0) quiet = 1'b0;
      if (result_take === 1'b1) return;
    end
    bail();
  endtask

  task automatic get_bits(input int n, output logic [79:0] v);
    int got;
    got = 0;
    v = '0;
    for (int i = 0; i < 2000 && got < n; i++) begin
      @(posedge clk);
      #1;
      if (bit_valid === 1'b1) begin
        v = {v[78:0], bit_value};
        got++;
      end
    end
    if (got < n) bail();
  endtask

  function automatic logic [79:0] frame(input logic long, input logic [1:0] cnt);
    logic [15:0] sync;
    logic [63:0] pay;
    logic [15:0] c;
    int          n;
    sync = {ratio_select_high_pin, ratio_select_low_pin, gain_select_high_pin,
            gain_select_low_pin, bias_select_pin, cnt, 1'b0, twf_pkg::SYNC_BYTE};
    pay = long ? {sync, channel0_result, channel1_result}
               : {16'h0000, sync, channel0_result[23:8], channel1_result[23:8]};
    n = long ? 64 : 48;
    c = twf_pkg::CRC_INIT;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ pay[i]) ? twf_pkg::CRC_POLY : 16'h0000);
    end
    return long ? {pay, c} : {16'h0000, pay[47:0], c};
  endfunction

  task automatic check_group(input logic long, input int n);
    logic [79:0] v;
    for (int f = 0; f < 4; f++) begin
      get_bits(n, v);
      check(v, frame(long, f[1:0]));
    end
  endtask

  task automatic trip(output int n);
    @(negedge clk);
    hold_high = 1'b1;
    n = 0;
    while (watchdog_reset !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) bail();
    end
    @(negedge clk);
    hold_high = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int          bits;
    int          n;
    logic        quiet;
    logic [79:0] v;
    failures = 0;
    checks_done = 0;
    wd_pulses = 0;
    rst_b = 1'b0;
    run = 1'b0;
    hold_high = 1'b0;
    skew = 1'b0;
    interface_select_pin = 1'b1;
    ratio_select_low_pin = 1'b0;
    ratio_select_high_pin = 1'b0;
    gain_select_low_pin = 1'b0;
    gain_select_high_pin = 1'b1;
    bias_select_pin = 1'b1;
    channel0_result = 24'hC3A51E;
    channel1_result = 24'h5A0F96;
    repeat (10) @(negedge clk);
    check({two_wire_mode, converter_reset, serial_out}, 3'h2);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check({two_wire_mode, ratio_code, gain_code, bias_code}, 6'h25);
    run = 1'b1;
    wait_take(bits, quiet);
    check(quiet, 1'b1);
    check(bits >= 2 * 64 + 12 * 64 && bits <= 2 * 64 + 12 * 64 + 1, 1'b1);
    check_group(1'b0, 64);
    check_group(1'b0, 64);
    run = 1'b0;
    repeat (1200) @(negedge clk);
    check(wd_pulses, 0);
    repeat (2) begin
      hold_high = 1'b1;
      repeat (300) @(negedge clk);
      hold_high = 1'b0;
      repeat (20) @(negedge clk);
    end
    check(wd_pulses, 0);
    interface_select_pin = 1'b0;
    ratio_select_low_pin = 1'b1;
    repeat (5) @(negedge clk);
    trip(n);
    check(n >= 362 && n <= 367, 1'b1);
    check(two_wire_mode, 1'b0);
    interface_select_pin = 1'b1;
    repeat (6) @(negedge clk);
    check({two_wire_mode, ratio_code}, 3'h1);
    trip(n);
    check({two_wire_mode, ratio_code, gain_code, bias_code}, 6'h2D);
    run = 1'b1;
    wait_take(bits, quiet);
    check(bits >= 2 * 128 + 12 * 128 && bits <= 2 * 128 + 12 * 128 + 1, 1'b1);
    check_group(1'b1, 80);
    get_bits(100, v);
    check(v, 80'h0);
    skew = 1'b1;
    wait_take(bits, quiet);
    check({quiet, bits[9:0]}, {1'b1, 10'h05C});
    check_group(1'b1, 80);
    tally_and_finish();
  end
endmodule
